// file: hdl/conversion_timing_control.sv
// conversion timing control: divider counters, period adjust and lite register slave
`timescale 1ns/1ps

// Summary of operation
// RL1: divider a below mode minimum halts port
// RL2: adjust registers are signed two's complement
// RL3: transmit sum 0 or 1 loads plain divider
// RL4: receive sum 0 or 1 loads plain divider
// RL5: negative transmit sum wraps by adding 40h
// RL6: negative receive sum wraps by adding 40h
// RL7: divider a of 0 or 1 stops conversion
// RL8: divider b of 0 or 1 becomes 24h
// RL9: dac value holds without new commands
// RL10: host keeps frame syncs 19.2 kHz apart
// RL11: adjust command adjusts ongoing transmit period
// RL12: adjustment applied near end of period
// RL13: receive adjust current period else next one
// RL14: one command adjusts exactly one period pair
// RL15: drop receive adjust when already scheduled
// RL16: transmit secondary values always taken immediately
// RL17: receive values ignored while adjustment applies
// RL18: primary low bits select counter a load
// RL19: counters reload every conversion period
// RL20: reset sets 9, 1, 24h each direction
// RL21: synchronous mode runs from transmit counters
// RL22: counter a filter clock, b conversion
module conversion_timing_control (
    input  wire logic                        i_clk,       // 40 MHz master clock
    input  wire logic                        i_rstn,      // async reset, active low
    input  wire logic                        i_ce,        // clock enable, freezes state
    input  wire logic                        i_word_mode, // pin: 1 word, 0 byte mode
    input  wire conv_timing_pkg::axi_req_t   i_axi,       // lite bus request
    output conv_timing_pkg::axi_rsp_t        o_axi,       // lite bus answer
    output conv_timing_pkg::conv_out_t       o_conv       // timing outputs
);
    import conv_timing_pkg::*;

    state_t s_q;        // registered state
    state_t s_d;        // next state
    dir_t   tx_step;    // transmit counter step
    dir_t   rx_step;    // receive counter step
    logic   sync_mode;  // directions share transmit timing
    logic   shutdown;   // a divider a of 0 or 1
    logic   port_halt;  // a divider a below the mode minimum
    logic   rx_lock;    // receive adjustment being applied now
    logic   commit;     // a captured write executes
    logic   prim_cmd;   // primary word accepted
    logic   sec_cmd;    // secondary word accepted
    logic   aw_hs;      // write address taken
    logic   w_hs;       // write data taken
    logic   ar_hs;      // read address taken

    // counter a load value for the last segment of a period
    function automatic logic [5:0] a_load(input logic [5:0] div, input logic [5:0] adj,
                                          input adj_mode_t mode);
        logic signed [7:0] sum;
        logic signed [7:0] wrap;
        sum  = 8'sh00;
        wrap = 8'sh00;
        a_load = div;
        // RL2: sign-extended adjust
        unique case (mode)
            ADJ_PLUS:  sum = signed'({2'b00, div}) + signed'({{2{adj[5]}}, adj});
            ADJ_MINUS: sum = signed'({2'b00, div}) - signed'({{2{adj[5]}}, adj});
            ADJ_NONE:  sum = signed'({2'b00, div});
            default:   sum = signed'({2'b00, div});
        endcase
        wrap = sum + MOD64_ADD;
        if (sum == 8'sh00 || sum == 8'sh01) begin
            // RL3 RL4: fall back to divider
            a_load = div;
        end else if (sum < 8'sh00) begin
            // RL5 RL6: modulo 64 wrap
            a_load = wrap[5:0];
        end else begin
            a_load = sum[5:0];
        end
    endfunction : a_load

    // replace an illegal divider b
    function automatic logic [5:0] fix_b(input logic [5:0] v);
        // RL8: 0 or 1 becomes 24h
        fix_b = (v <= 6'h01) ? DIV_B_FIX : v;
    endfunction : fix_b

    // one master clock of a direction; adjusted load goes into the last a segment
    function automatic dir_t dir_step(input logic [5:0] cnt_a, input logic [5:0] cnt_b,
                                      input logic [5:0] div_a, input logic [5:0] adj,
                                      input logic [5:0] div_b, input adj_mode_t mode);
        dir_step.cnt_a = cnt_a;
        dir_step.cnt_b = cnt_b;
        dir_step.fclk  = 1'b0;
        dir_step.conv  = 1'b0;
        dir_step.used  = 1'b0;
        if (cnt_a > 6'h01) begin
            // RL22: counter a divides master clock
            dir_step.cnt_a = cnt_a - 6'h01;
        end else begin
            dir_step.fclk = 1'b1;
            if (cnt_b <= 6'h01) begin
                // RL19: both counters reload per period
                dir_step.conv  = 1'b1;
                dir_step.cnt_b = div_b;
                dir_step.cnt_a = div_a;
            end else begin
                dir_step.cnt_b = cnt_b - 6'h01;
                if (cnt_b == 6'h02) begin
                    // RL12: adjust only the final segment
                    dir_step.cnt_a = a_load(div_a, adj, mode);
                    dir_step.used  = (mode != ADJ_NONE);
                end else begin
                    dir_step.cnt_a = div_a;
                end
            end
        end
    endfunction : dir_step

    // status terms derived from the registers
    assign sync_mode = s_q.ctrl[CTRL_SYNC_BIT];
    // RL7: divider a of 0 or 1 stops conversion
    assign shutdown  = (s_q.tx_div_a <= 6'h01) || (!sync_mode && s_q.rx_div_a <= 6'h01);
    // RL1: minimum depends on the synchronised mode pin
    assign port_halt = (s_q.tx_div_a < (s_q.word_s2 ? MIN_A_WORD : MIN_A_BYTE))
                    || (!sync_mode && s_q.rx_div_a < (s_q.word_s2 ? MIN_A_WORD : MIN_A_BYTE));
    assign rx_lock   = (s_q.rx_adj_mode != ADJ_NONE) && (s_q.rx_cnt_b <= 6'h01);
    assign tx_step   = dir_step(s_q.tx_cnt_a, s_q.tx_cnt_b, s_q.tx_div_a, s_q.tx_adj,
                                s_q.tx_div_b, s_q.tx_adj_mode);
    assign rx_step   = dir_step(s_q.rx_cnt_a, s_q.rx_cnt_b, s_q.rx_div_a, s_q.rx_adj,
                                s_q.rx_div_b, s_q.rx_adj_mode);

    // bus handshakes; one write and one read in flight
    assign aw_hs    = i_axi.awvalid && !s_q.aw_ok && !s_q.bvalid;
    assign w_hs     = i_axi.wvalid && !s_q.w_ok && !s_q.bvalid;
    assign ar_hs    = i_axi.arvalid && !s_q.rvalid;
    assign commit   = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
    // a halted port ignores commands, so the halt clears only by reset or by a change of the synchronised mode pin
    assign prim_cmd = commit && s_q.strb_ok && !port_halt && s_q.aw_addr == OFS_PRIMARY;
    assign sec_cmd  = commit && s_q.strb_ok && !port_halt && s_q.sec_pend
                   && s_q.aw_addr == OFS_SECONDARY;

    // next state
    always_comb begin
        s_d = s_q;
        s_d.word_s1 = i_word_mode;
        s_d.word_s2 = s_q.word_s1;
        s_d.tx_conv = 1'b0;
        s_d.rx_conv = 1'b0;
        s_d.tx_fclk = 1'b0;
        s_d.rx_fclk = 1'b0;
        // write channel capture, either order
        if (aw_hs) begin
            s_d.aw_ok   = 1'b1;
            s_d.aw_addr = i_axi.awaddr;
        end
        if (w_hs) begin
            s_d.w_ok    = 1'b1;
            s_d.wdata   = i_axi.wdata;
            s_d.strb_ok = (i_axi.wstrb[1:0] == 2'b11);
        end
        if (s_q.bvalid && i_axi.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (commit) begin
            s_d.aw_ok  = 1'b0;
            s_d.w_ok   = 1'b0;
            s_d.bvalid = 1'b1;
            // only the two command words are writable
            s_d.bresp  = (s_q.aw_addr == OFS_PRIMARY || s_q.aw_addr == OFS_SECONDARY)
                       ? RESP_OKAY : RESP_SLVERR;
        end
        // read channel
        if (s_q.rvalid && i_axi.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            unique case (i_axi.araddr)
                OFS_PRIMARY:   s_d.rdata = {16'h0000, s_q.dac, 2'b00};
                OFS_SECONDARY: s_d.rdata = {22'h000000, s_q.ctrl};
                OFS_STATUS:    s_d.rdata = {24'h000000, s_q.word_s2, sync_mode,
                                            s_q.rx_adj_next != ADJ_NONE,
                                            s_q.rx_adj_mode != ADJ_NONE,
                                            s_q.tx_adj_mode != ADJ_NONE,
                                            s_q.sec_pend, shutdown, port_halt};
                OFS_DIVIDERS:  s_d.rdata = {8'h00, s_q.rx_div_b, s_q.rx_div_a,
                                            s_q.tx_div_b, s_q.tx_div_a};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        // transmit counters; stopped while shut down
        if (!shutdown) begin
            s_d.tx_cnt_a = tx_step.cnt_a;
            s_d.tx_cnt_b = tx_step.cnt_b;
            s_d.tx_fclk  = tx_step.fclk;
            s_d.tx_conv  = tx_step.conv;
            // RL14: adjustment consumed once
            if (tx_step.used) begin
                s_d.tx_adj_mode = ADJ_NONE;
            end
        end
        // RL21: receive counters idle in synchronous mode
        if (!shutdown && !sync_mode) begin
            s_d.rx_cnt_a = rx_step.cnt_a;
            s_d.rx_cnt_b = rx_step.cnt_b;
            s_d.rx_fclk  = rx_step.fclk;
            s_d.rx_conv  = rx_step.conv;
            if (rx_step.used) begin
                s_d.rx_adj_mode = ADJ_NONE;
            end
            // RL13: deferred adjustment moves to the new period
            if (rx_step.conv) begin
                s_d.rx_adj_mode = s_q.rx_adj_next;
                s_d.rx_adj_next = ADJ_NONE;
            end
        end
        // RL18: primary word selects the counter a load
        if (prim_cmd) begin
            // RL9: dac only changes on a new primary word
            s_d.dac      = s_q.wdata[15:2];
            s_d.sec_pend = (s_q.wdata[1:0] == LD_SECOND);
            if (s_q.wdata[1:0] == LD_PLUS || s_q.wdata[1:0] == LD_MINUS) begin
                // RL11: arm the ongoing transmit period
                s_d.tx_adj_mode = adj_mode_t'(s_q.wdata[1:0]);
                // RL13 RL15: current, next or discarded
                if (s_q.rx_cnt_b > 6'h01 && s_q.rx_adj_mode == ADJ_NONE) begin
                    s_d.rx_adj_mode = adj_mode_t'(s_q.wdata[1:0]);
                end else if (s_q.rx_cnt_b <= 6'h01 && s_q.rx_adj_next == ADJ_NONE) begin
                    s_d.rx_adj_next = adj_mode_t'(s_q.wdata[1:0]);
                end
            end
        end
        // RL16: transmit fields always taken
        if (sec_cmd) begin
            s_d.sec_pend = 1'b0;
            unique case (s_q.wdata[1:0])
                SEL_A: begin
                    s_d.tx_div_a = {1'b0, s_q.wdata[FLD_HI_LSB +: 5]};
                    // RL17: receive field dropped while locked
                    if (!rx_lock) s_d.rx_div_a = {1'b0, s_q.wdata[FLD_LO_LSB +: 5]};
                end
                SEL_ADJ: begin
                    s_d.tx_adj = s_q.wdata[FLD_HI_LSB +: 6];
                    if (!rx_lock) s_d.rx_adj = s_q.wdata[FLD_LO_LSB +: 6];
                end
                SEL_B: begin
                    s_d.tx_div_b = fix_b(s_q.wdata[FLD_HI_LSB +: 6]);
                    if (!rx_lock) s_d.rx_div_b = fix_b(s_q.wdata[FLD_LO_LSB +: 6]);
                end
                SEL_CTRL: s_d.ctrl = s_q.wdata[9:0] & CTRL_MASK;
            endcase
        end
    end

    // state register; the enable freezes everything, synchroniser included
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '0;
            // RL20: power-on divider set
            s_q.tx_div_a <= RST_DIV_A;
            s_q.tx_adj   <= RST_ADJ;
            s_q.tx_div_b <= RST_DIV_B;
            s_q.rx_div_a <= RST_DIV_A;
            s_q.rx_adj   <= RST_ADJ;
            s_q.rx_div_b <= RST_DIV_B;
            s_q.ctrl     <= RST_CTRL;
            s_q.tx_cnt_a <= RST_DIV_A;
            s_q.tx_cnt_b <= RST_DIV_B;
            s_q.rx_cnt_a <= RST_DIV_A;
            s_q.rx_cnt_b <= RST_DIV_B;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // bus outputs
    assign o_axi.awready = !s_q.aw_ok && !s_q.bvalid;
    assign o_axi.wready  = !s_q.w_ok && !s_q.bvalid;
    assign o_axi.bvalid  = s_q.bvalid;
    assign o_axi.bresp   = s_q.bresp;
    assign o_axi.arready = !s_q.rvalid;
    assign o_axi.rvalid  = s_q.rvalid;
    assign o_axi.rdata   = s_q.rdata;
    assign o_axi.rresp   = s_q.rresp;
    // timing outputs; synchronous mode copies transmit timing to receive
    assign o_conv.tx_convert    = s_q.tx_conv;
    assign o_conv.rx_convert    = sync_mode ? s_q.tx_conv : s_q.rx_conv;
    assign o_conv.tx_filter_clk = s_q.tx_fclk;
    assign o_conv.rx_filter_clk = sync_mode ? s_q.tx_fclk : s_q.rx_fclk;
    assign o_conv.shutdown      = shutdown;
    assign o_conv.port_halt     = port_halt;
    assign o_conv.dac           = s_q.dac;
    assign o_conv.ctrl          = s_q.ctrl;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence seq_tx_pulse;
        i_ce && s_q.tx_conv;
    endsequence

    chk_div_b_legal: assert property (s_q.tx_div_b > 6'h01 && s_q.rx_div_b > 6'h01) // RL8
        else $error("divider b holds 0 or 1");
    chk_shutdown_quiet: assert property ((i_ce && s_q.tx_div_a <= 6'h01) |=> !s_q.tx_conv) // RL7
        else $error("conversion pulse while shut down");
    chk_halt_ignores: assert property ((i_ce && commit && port_halt) |=> $stable(s_q.dac)) // RL1
        else $error("halted port accepted a command");
    chk_dac_hold: assert property ((i_ce && !prim_cmd) |=> $stable(s_q.dac)) // RL9
        else $error("dac value changed without a command");
    chk_adj_once: assert property ((i_ce && !shutdown && tx_step.used && !prim_cmd) // RL14
        |=> s_q.tx_adj_mode == ADJ_NONE)
        else $error("transmit adjustment not consumed");
    chk_load_legal: assert property ((s_q.tx_div_a > 6'h01 && tx_step.fclk) // RL3
        |-> tx_step.cnt_a > 6'h01)
        else $error("counter a loaded with 0 or 1");
    chk_rx_discard: assert property ((i_ce && prim_cmd && !shutdown && !sync_mode // RL15
        && s_q.rx_adj_mode != ADJ_NONE && s_q.rx_cnt_b > 6'h01 && !rx_step.used)
        |=> s_q.rx_adj_mode == $past(s_q.rx_adj_mode))
        else $error("scheduled receive adjustment overwritten");
    chk_sync_rx_idle: assert property ((i_ce && sync_mode) // RL21
        |=> $stable(s_q.rx_cnt_a) && $stable(s_q.rx_cnt_b))
        else $error("receive counters run in synchronous mode");
    chk_rx_lock_hold: assert property ((i_ce && sec_cmd && rx_lock) // RL17
        |=> $stable(s_q.rx_div_a) && $stable(s_q.rx_adj) && $stable(s_q.rx_div_b))
        else $error("receive value taken while adjustment applies");
    chk_period_gap: assert property (seq_tx_pulse ##1 i_ce |-> !s_q.tx_conv) // RL19
        else $error("back to back conversion pulses");
endmodule : conversion_timing_control

// file: pkg/conv_timing_pkg.sv
// package: constants, register map and carrier types for the conversion timing block
package conv_timing_pkg;
    // register byte offsets on the lite bus
    localparam logic [7:0] OFS_PRIMARY   = 8'h00;  // command word, dac data
    localparam logic [7:0] OFS_SECONDARY = 8'h04;  // divider / control word
    localparam logic [7:0] OFS_STATUS    = 8'h08;  // read-only status
    localparam logic [7:0] OFS_DIVIDERS  = 8'h0c;  // read-only divider view
    // field positions inside command words
    localparam int unsigned FLD_HI_LSB = 9;        // transmit field low bit
    localparam int unsigned FLD_LO_LSB = 2;        // receive field low bit
    // values after reset
    localparam logic [5:0] RST_DIV_A = 6'h09;      // divider a, both directions
    localparam logic [5:0] RST_ADJ   = 6'h01;      // period adjust, both directions
    localparam logic [5:0] RST_DIV_B = 6'h24;      // divider b, both directions
    localparam logic [9:0] RST_CTRL  = 10'h2e4;    // control bits 9,7,6,5,2 set
    localparam logic [9:0] CTRL_MASK = 10'h2fc;    // writable control bits
    localparam int unsigned CTRL_SYNC_BIT = 5;     // 1 = synchronous directions
    // recovery and limit figures
    localparam logic [5:0] DIV_B_FIX  = 6'h24;     // replaces a divider b of 0 or 1
    localparam logic [5:0] MIN_A_WORD = 6'h04;     // least divider a, word mode
    localparam logic [5:0] MIN_A_BYTE = 6'h05;     // least divider a, byte mode
    localparam logic signed [7:0] MOD64_ADD = 8'sh40; // wrap for negative sums
    // low two bits of a primary word
    localparam logic [1:0] LD_PLAIN  = 2'b00;
    localparam logic [1:0] LD_PLUS   = 2'b01;
    localparam logic [1:0] LD_MINUS  = 2'b10;
    localparam logic [1:0] LD_SECOND = 2'b11;
    // low two bits of a secondary word
    localparam logic [1:0] SEL_A    = 2'b00;
    localparam logic [1:0] SEL_ADJ  = 2'b01;
    localparam logic [1:0] SEL_B    = 2'b10;
    localparam logic [1:0] SEL_CTRL = 2'b11;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // pending adjustment of one period
    typedef enum logic [1:0] {
        ADJ_NONE  = 2'b00,
        ADJ_PLUS  = 2'b01,
        ADJ_MINUS = 2'b10
    } adj_mode_t;

    // lite bus, master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_t;

    // lite bus, slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    // timing outputs toward the converters and filters
    typedef struct packed {
        logic        tx_convert;     // d/a conversion instant
        logic        rx_convert;     // a/d conversion instant
        logic        tx_filter_clk;  // transmit counter a terminal
        logic        rx_filter_clk;  // receive counter a terminal; transmit counter a terminal in synchronous mode
        logic        shutdown;       // conversion stopped
        logic        port_halt;      // serial port stopped
        logic [13:0] dac;            // held d/a value
        logic [9:0]  ctrl;           // control word
    } conv_out_t;

    // one step of a direction's counter pair
    typedef struct packed {
        logic [5:0] cnt_a;
        logic [5:0] cnt_b;
        logic       fclk;
        logic       conv;
        logic       used;
    } dir_t;

    // whole state of the block
    typedef struct packed {
        logic        aw_ok;
        logic [7:0]  aw_addr;
        logic        w_ok;
        logic [31:0] wdata;
        logic        strb_ok;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [5:0]  tx_div_a;
        logic [5:0]  tx_adj;
        logic [5:0]  tx_div_b;
        logic [5:0]  rx_div_a;
        logic [5:0]  rx_adj;
        logic [5:0]  rx_div_b;
        logic [9:0]  ctrl;
        logic [13:0] dac;
        logic        sec_pend;
        adj_mode_t   tx_adj_mode;
        adj_mode_t   rx_adj_mode;
        adj_mode_t   rx_adj_next;
        logic [5:0]  tx_cnt_a;
        logic [5:0]  tx_cnt_b;
        logic [5:0]  rx_cnt_a;
        logic [5:0]  rx_cnt_b;
        logic        tx_conv;
        logic        rx_conv;
        logic        tx_fclk;
        logic        rx_fclk;
        logic        word_s1;
        logic        word_s2;
    } state_t;
endpackage : conv_timing_pkg

// file: testbench/dsp_port_model.sv
// partner model: serial-port side sending frame words over the lite bus
`timescale 1ns/1ps
module dsp_port_model (
    input  wire logic                      i_clk, // master clock
    input  wire conv_timing_pkg::axi_rsp_t i_rsp, // slave answer
    output conv_timing_pkg::axi_req_t      o_req  // master request
);
    import conv_timing_pkg::*;
    // idle bus from time zero
    initial o_req = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;      // address still offered
        logic w;       // data still offered
        logic aw_rdy;  // awready seen before the edge
        logic w_rdy;   // wready seen before the edge
        logic b_seen;  // answer seen before the edge
        aw     = 1'b1;
        w      = 1'b1;
        b_seen = 1'b0;
        r      = 2'b00;
        // launch one edge later so back-to-back calls never collide
        @(posedge i_clk);
        o_req.awvalid <= 1'b1;
        o_req.awaddr  <= a;
        o_req.wvalid  <= 1'b1;
        o_req.wdata   <= d;
        o_req.wstrb   <= 4'hf;
        o_req.bready  <= 1'b1;
        // readies and bvalid are register outputs: the falling-edge value is
        // what the next rising edge samples, which avoids an edge race
        while (!b_seen) begin
            @(negedge i_clk);
            aw_rdy = i_rsp.awready;
            w_rdy  = i_rsp.wready;
            b_seen = (i_rsp.bvalid === 1'b1);
            r      = i_rsp.bresp;
            @(posedge i_clk);
            if (aw && aw_rdy) begin
                aw = 1'b0;
                o_req.awvalid <= 1'b0;
            end
            if (w && w_rdy) begin
                w = 1'b0;
                o_req.wvalid <= 1'b0;
            end
        end
        o_req.bready <= 1'b0;
    endtask : wr
    // register read, held until the answer edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_rdy;  // arready seen before the edge
        logic r_seen;  // answer seen before the edge
        r_seen = 1'b0;
        d      = 32'h00000000;
        r      = 2'b00;
        @(posedge i_clk);
        o_req.arvalid <= 1'b1;
        o_req.araddr  <= a;
        o_req.rready  <= 1'b1;
        while (!r_seen) begin
            @(negedge i_clk);
            ar_rdy = i_rsp.arready;
            r_seen = (i_rsp.rvalid === 1'b1);
            d      = i_rsp.rdata;
            r      = i_rsp.rresp;
            @(posedge i_clk);
            if (o_req.arvalid && ar_rdy) o_req.arvalid <= 1'b0;
        end
        o_req.rready <= 1'b0;
    endtask : rd
endmodule : dsp_port_model

// file: testbench/testbench.sv
// testbench: self-checking run of the conversion timing block
`timescale 1ns/1ps
module testbench;
    import conv_timing_pkg::*;
    logic      clk, rstn, ce, word_mode;  // clock, reset, enable, mode pin
    axi_req_t  req;                       // bus request from the model
    axi_rsp_t  rsp;                       // bus answer
    conv_out_t conv;                      // timing outputs
    int        error_cnt = 0;             // mismatches
    int        checked = 0;               // comparisons
    int        cyc = 0;                   // cycle count, also the hang guard
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    conversion_timing_control i_conversion_timing_control (.i_clk(clk), .i_rstn(rstn),
        .i_ce(ce), .i_word_mode(word_mode), .i_axi(req), .o_axi(rsp), .o_conv(conv));
    dsp_port_model i_dsp_port_model (.i_clk(clk), .i_rsp(rsp), .o_req(req));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard: whole run needs well under this
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        if (error_cnt == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic rst();
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
    endtask : rst
    // one-cycle pulse, so look at every edge
    task automatic wait_conv();
        do @(negedge clk); while (conv.tx_convert !== 1'b1);
    endtask : wait_conv
    // receive instant, looked at between edges like the transmit one
    task automatic wait_rx();
        do @(negedge clk); while (conv.rx_convert !== 1'b1);
    endtask : wait_rx
    task automatic sec(input logic [31:0] w);
        i_dsp_port_model.wr(OFS_PRIMARY, 32'h3, r);
        i_dsp_port_model.wr(OFS_SECONDARY, w, r);
    endtask : sec
    task automatic t_reset_vals();
        i_dsp_port_model.rd(OFS_DIVIDERS, d, r);
        chk(d, {8'h0, RST_DIV_B, RST_DIV_A, RST_DIV_B, RST_DIV_A});
        i_dsp_port_model.rd(OFS_SECONDARY, d, r);
        chk(d, 32'h2e4);
        i_dsp_port_model.rd(8'h10, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        i_dsp_port_model.wr(OFS_STATUS, 32'h0, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask : t_reset_vals
    task automatic t_period();
        wait_conv();
        t0 = cyc;
        wait_conv();
        chk(cyc - t0, 9 * 36);
    endtask : t_period
    // adjusted period: a * (b - 1) plus the adjusted last segment
    task automatic t_adjust(input logic [5:0] adj, input logic [1:0] mode, input int last);
        sec({17'h0, adj, 7'h0, SEL_ADJ});
        wait_conv();
        t0 = cyc;
        i_dsp_port_model.wr(OFS_PRIMARY, {30'h0, mode}, r);
        wait_conv();
        chk(cyc - t0, 9 * 35 + last);
        t0 = cyc;
        wait_conv();
        chk(cyc - t0, 9 * 36);
    endtask : t_adjust
    task automatic t_div_b();
        sec({17'h0, 6'h0, 1'b0, 6'h1, SEL_B});
        i_dsp_port_model.rd(OFS_DIVIDERS, d, r);
        chk(d, {8'h0, DIV_B_FIX, RST_DIV_A, DIV_B_FIX, RST_DIV_A});
    endtask : t_div_b
    task automatic t_dac();
        i_dsp_port_model.wr(OFS_PRIMARY, 32'hbee0, r);
        chk({18'h0, conv.dac}, {18'h0, 14'h2fb8});
        repeat (400) @(posedge clk);
        chk({18'h0, conv.dac}, {18'h0, 14'h2fb8});
    endtask : t_dac
    // asynchronous mode: receive counters, receive adjust and discard
    task automatic t_async();
        sec({22'h0, (RST_CTRL & 10'h3df) | {8'h00, SEL_CTRL}});
        chk({22'h0, conv.ctrl}, {22'h0, RST_CTRL & 10'h3df});
        wait_rx();
        t0 = cyc;
        wait_rx();
        chk(cyc - t0, 9 * 36);
        sec({17'h0, 6'h00, 1'b0, 6'h02, SEL_ADJ});
        wait_rx();
        t0 = cyc;
        i_dsp_port_model.wr(OFS_PRIMARY, {30'h0, LD_PLUS}, r);
        i_dsp_port_model.wr(OFS_PRIMARY, {30'h0, LD_MINUS}, r);
        wait_rx();
        chk(cyc - t0, 9 * 35 + 11);
        t0 = cyc;
        wait_rx();
        chk(cyc - t0, 9 * 36);
    endtask : t_async
    task automatic t_limits();
        sec({18'h0, 5'd4, 2'b0, 5'd9, SEL_A});
        chk({31'h0, conv.port_halt}, 32'h0);
        word_mode <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, conv.port_halt}, 32'h1);
        rst();
        sec({18'h0, 5'd1, 2'b0, 5'd9, SEL_A});
        chk({31'h0, conv.shutdown}, 32'h1);
        rst();
    endtask : t_limits
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        word_mode = 1'b1;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset_vals();
        t_period();
        t_adjust(6'h01, LD_PLUS, 10);
        t_adjust(6'h02, LD_MINUS, 7);
        t_adjust(6'h08, LD_MINUS, 9);
        t_adjust(6'h34, LD_PLUS, 61);
        t_div_b();
        t_dac();
        t_async();
        t_limits();
        end_sim();
    end
endmodule : testbench
